//--- common/trap_seq_regs.vh
`ifndef TRAP_SEQ_REGS_VH
`define TRAP_SEQ_REGS_VH

// operation codes presented by the decode pipeline
`define OP_BPT      4'h0
`define OP_BUGCHK   4'h1
`define OP_GENTRAP  4'h2
`define OP_CALLSYS  4'h3
`define OP_CLRFEN   4'h4
`define OP_RDUNIQ   4'h5
`define OP_WRUNIQ   4'h6
`define OP_URTI     4'h7
`define OP_IMB      4'h8
`define OP_CFLUSH   4'h9

// exception codes
`define EXC_NONE    3'h0
`define EXC_KSNV    3'h1
`define EXC_MCHK    3'h2
`define EXC_ILLOP   3'h3
`define EXC_RSVD    3'h4
`define EXC_MEMF    3'h5

// register offsets (byte addresses, 64-bit words)
`define REG_CTRL    6'h00
`define REG_KPTR    6'h08
`define REG_KSS     6'h10
`define REG_USS     6'h18
`define REG_IFVEC   6'h20
`define REG_SYSVEC  6'h28
`define REG_CBB     6'h30
`define REG_UNIQ    6'h38

// control register fields
`define CTRL_FLT    4
`define CTRL_INTR   5
`define CTRL_LOCK   6

// processor status layout
`define ST_MODE     3
`define ST_RST      4'h0
`define ST_SYSCALL  64'h0000_0000_0000_0008

// frame geometry
`define FRAME_BYTES 64'h0000_0000_0000_0030
`define FLT_OFF     64'h0000_0000_0000_0028
`define QW_STEP     64'h0000_0000_0000_0008
`define TRAP_STEPS  3'h5
`define SYS_STEPS   3'h2
`define URTI_STEPS  3'h7
`define FLT_STEPS   3'h1

// result write mask bits
`define RES_SP      0
`define RES_GP      1
`define RES_A0      2
`define RES_A1      3
`define RES_A2      4
`define RES_V0      5
`define RES_AT      6
`define RES_PC      7

`endif

//--- hdl/trap_call_return_sequencer.v
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "trap_seq_regs.vh"

module trap_call_return_sequencer #(
  parameter DW = 64
) (
  input  wire          mclk_in,
  input  wire          rst_n_in,
  // wishbone slave
  input  wire          wb_cyc_in,
  input  wire          wb_stb_in,
  input  wire          wb_we_in,
  input  wire [5:0]    wb_adr_in,
  input  wire [7:0]    wb_sel_in,
  input  wire [DW-1:0] wb_dat_in,
  output reg  [DW-1:0] wb_dat_out,
  output reg           wb_ack_out,
  // decode side
  input  wire          op_valid_in,
  input  wire [3:0]    op_code_in,
  input  wire [DW-1:0] op_pc_next_in,
  input  wire [DW-1:0] op_sp_in,
  input  wire [DW-1:0] op_gp_in,
  input  wire [DW-1:0] op_a0_in,
  input  wire [DW-1:0] op_a1_in,
  input  wire [DW-1:0] op_a2_in,
  input  wire          lock_set_in,
  input  wire          intr_set_in,
  output reg           busy_out,
  output reg           done_out,
  output reg  [7:0]    res_we_out,
  output reg  [DW-1:0] res_sp_out,
  output reg  [DW-1:0] res_gp_out,
  output reg  [DW-1:0] res_a0_out,
  output reg  [DW-1:0] res_a1_out,
  output reg  [DW-1:0] res_a2_out,
  output reg  [DW-1:0] res_v0_out,
  output reg  [DW-1:0] res_at_out,
  output reg  [DW-1:0] res_pc_out,
  output reg           exc_out,
  output reg  [2:0]    exc_code_out,
  output reg           flush_out,
  output reg  [DW-1:0] flush_pfn_out,
  output reg  [3:0]    status_out,
  output reg           float_enable_bit_out,
  // stack memory
  output reg           mem_req_out,
  output reg           mem_we_out,
  output reg  [DW-1:0] mem_addr_out,
  output reg  [DW-1:0] mem_wdata_out,
  input  wire [DW-1:0] mem_rdata_in,
  input  wire          mem_ack_in,
  input  wire          mem_err_in
);

  localparam S_IDLE = 1'b0;
  localparam S_MEM  = 1'b1;

  reg          state_r;
  reg [3:0]    op_r;
  reg [2:0]    step_r;
  reg [2:0]    last_r;
  reg          user_r;
  reg [3:0]    old_ps_r;
  reg [DW-1:0] base_r;
  reg [DW-1:0] pc_l_r;
  reg [DW-1:0] sp_l_r;
  reg [DW-1:0] gp_l_r;
  reg [DW-1:0] a0_l_r;
  reg [DW-1:0] a1_l_r;
  reg [DW-1:0] a2_l_r;
  reg [DW-1:0] ld_r [0:7];

  reg [DW-1:0] kernel_global_ptr_r;
  reg [DW-1:0] kernel_stack_save_r;
  reg [DW-1:0] user_stack_save_r;
  reg [DW-1:0] instr_fault_vector_r;
  reg [DW-1:0] syscall_vector_r;
  reg [DW-1:0] context_block_base_r;
  reg [DW-1:0] unique_r;
  reg          intr_flag_r;
  reg          lock_flag_r;

  wire          wb_hit     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire          wb_wr      = wb_hit & wb_we_in;
  wire          user_mode  = status_out[`ST_MODE];
  wire [DW-1:0] trap_stack = user_mode ? kernel_stack_save_r : op_sp_in;
  wire [DW-1:0] trap_base  = trap_stack - `FRAME_BYTES;
  wire [DW-1:0] sys_base   = kernel_stack_save_r - `FRAME_BYTES;
  wire [DW-1:0] ctrl_word  = {{(DW-7){1'b0}}, lock_flag_r, intr_flag_r,
                              float_enable_bit_out, status_out};
  wire [DW-1:0] urti_ps    = ld_r[2];

  function [DW-1:0] merge;
    input [DW-1:0] old;
    input [DW-1:0] val;
    input [7:0]    sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 8; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  // frame quadword for a given slot of a trap or system call frame
  function [DW-1:0] frame_word;
    input [2:0] s;
    begin
      case (s)
        3'h0:    frame_word = (op_r == `OP_CALLSYS) ? `ST_SYSCALL :
                              {{(DW-4){1'b0}}, old_ps_r};
        3'h1:    frame_word = pc_l_r;
        3'h2:    frame_word = gp_l_r;
        3'h3:    frame_word = a0_l_r;
        3'h4:    frame_word = a1_l_r;
        3'h5:    frame_word = a2_l_r;
        default: frame_word = {DW{1'b0}};
      endcase
    end
  endfunction

  always @(posedge mclk_in) begin
    if (state_r == S_MEM && mem_ack_in && !mem_we_out) begin
      ld_r[step_r] <= mem_rdata_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wb_ack_out           <= 1'b0;
      wb_dat_out           <= {DW{1'b0}};
      state_r              <= S_IDLE;
      op_r                 <= 4'h0;
      step_r               <= 3'h0;
      last_r               <= 3'h0;
      user_r               <= 1'b0;
      old_ps_r             <= 4'h0;
      base_r               <= {DW{1'b0}};
      pc_l_r               <= {DW{1'b0}};
      sp_l_r               <= {DW{1'b0}};
      gp_l_r               <= {DW{1'b0}};
      a0_l_r               <= {DW{1'b0}};
      a1_l_r               <= {DW{1'b0}};
      a2_l_r               <= {DW{1'b0}};
      kernel_global_ptr_r  <= {DW{1'b0}};
      kernel_stack_save_r  <= {DW{1'b0}};
      user_stack_save_r    <= {DW{1'b0}};
      instr_fault_vector_r <= {DW{1'b0}};
      syscall_vector_r     <= {DW{1'b0}};
      context_block_base_r <= {DW{1'b0}};
      unique_r             <= {DW{1'b0}};
      intr_flag_r          <= 1'b0;
      lock_flag_r          <= 1'b0;
      status_out           <= `ST_RST;
      float_enable_bit_out <= 1'b0;
      busy_out             <= 1'b0;
      done_out             <= 1'b0;
      res_we_out           <= 8'h00;
      res_sp_out           <= {DW{1'b0}};
      res_gp_out           <= {DW{1'b0}};
      res_a0_out           <= {DW{1'b0}};
      res_a1_out           <= {DW{1'b0}};
      res_a2_out           <= {DW{1'b0}};
      res_v0_out           <= {DW{1'b0}};
      res_at_out           <= {DW{1'b0}};
      res_pc_out           <= {DW{1'b0}};
      exc_out              <= 1'b0;
      exc_code_out         <= `EXC_NONE;
      flush_out            <= 1'b0;
      flush_pfn_out        <= {DW{1'b0}};
      mem_req_out          <= 1'b0;
      mem_we_out           <= 1'b0;
      mem_addr_out         <= {DW{1'b0}};
      mem_wdata_out        <= {DW{1'b0}};
    end else begin
      done_out   <= 1'b0;
      exc_out    <= 1'b0;
      flush_out  <= 1'b0;
      res_we_out <= 8'h00;
      wb_ack_out <= wb_hit;
      // register bus: reads answer one cycle after the strobe
      if (wb_hit) begin
        if (wb_adr_in == `REG_CTRL) begin
          wb_dat_out <= ctrl_word;
        end else if (wb_adr_in == `REG_KPTR) begin
          wb_dat_out <= kernel_global_ptr_r;
        end else if (wb_adr_in == `REG_KSS) begin
          wb_dat_out <= kernel_stack_save_r;
        end else if (wb_adr_in == `REG_USS) begin
          wb_dat_out <= user_stack_save_r;
        end else if (wb_adr_in == `REG_IFVEC) begin
          wb_dat_out <= instr_fault_vector_r;
        end else if (wb_adr_in == `REG_SYSVEC) begin
          wb_dat_out <= syscall_vector_r;
        end else if (wb_adr_in == `REG_CBB) begin
          wb_dat_out <= context_block_base_r;
        end else if (wb_adr_in == `REG_UNIQ) begin
          wb_dat_out <= unique_r;
        end else begin
          wb_dat_out <= {DW{1'b0}};
        end
      end
      if (wb_wr) begin
        if (wb_adr_in == `REG_CTRL) begin
          if (wb_sel_in[0]) begin
            status_out           <= wb_dat_in[3:0];
            float_enable_bit_out <= wb_dat_in[`CTRL_FLT];
            intr_flag_r          <= wb_dat_in[`CTRL_INTR];
            lock_flag_r          <= wb_dat_in[`CTRL_LOCK];
          end
        end else if (wb_adr_in == `REG_KPTR) begin
          kernel_global_ptr_r <= merge(kernel_global_ptr_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_KSS) begin
          kernel_stack_save_r <= merge(kernel_stack_save_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_USS) begin
          user_stack_save_r <= merge(user_stack_save_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_IFVEC) begin
          instr_fault_vector_r <= merge(instr_fault_vector_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_SYSVEC) begin
          syscall_vector_r <= merge(syscall_vector_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_CBB) begin
          context_block_base_r <= merge(context_block_base_r, wb_dat_in, wb_sel_in);
        end else if (wb_adr_in == `REG_UNIQ) begin
          unique_r <= merge(unique_r, wb_dat_in, wb_sel_in);
        end
      end

      case (state_r)
        S_IDLE: begin
          if (op_valid_in) begin
            op_r     <= op_code_in;
            user_r   <= user_mode;
            old_ps_r <= status_out;
            pc_l_r   <= op_pc_next_in;
            sp_l_r   <= op_sp_in;
            gp_l_r   <= op_gp_in;
            a0_l_r   <= op_a0_in;
            a1_l_r   <= op_a1_in;
            a2_l_r   <= op_a2_in;
            step_r   <= 3'h0;
            case (op_code_in)
              `OP_BPT, `OP_BUGCHK, `OP_GENTRAP: begin
                if (trap_base[2:0] != 3'h0) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_KSNV;
                end else begin
                  state_r       <= S_MEM;
                  busy_out      <= 1'b1;
                  base_r        <= trap_base;
                  last_r        <= `TRAP_STEPS;
                  mem_req_out   <= 1'b1;
                  mem_we_out    <= 1'b1;
                  mem_addr_out  <= trap_base;
                  mem_wdata_out <= {{(DW-4){1'b0}}, status_out};
                end
              end
              `OP_CALLSYS: begin
                if (!user_mode) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_MCHK;
                end else if (sys_base[2:0] != 3'h0) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_KSNV;
                end else begin
                  state_r       <= S_MEM;
                  busy_out      <= 1'b1;
                  base_r        <= sys_base;
                  last_r        <= `SYS_STEPS;
                  mem_req_out   <= 1'b1;
                  mem_we_out    <= 1'b1;
                  mem_addr_out  <= sys_base;
                  mem_wdata_out <= `ST_SYSCALL;
                end
              end
              `OP_CLRFEN: begin
                // read-modify-write keeps the other bits of the block word
                state_r      <= S_MEM;
                busy_out     <= 1'b1;
                last_r       <= `FLT_STEPS;
                mem_req_out  <= 1'b1;
                mem_we_out   <= 1'b0;
                mem_addr_out <= context_block_base_r + `FLT_OFF;
              end
              `OP_RDUNIQ: begin
                done_out             <= 1'b1;
                res_v0_out           <= unique_r;
                res_we_out[`RES_V0]  <= 1'b1;
              end
              `OP_WRUNIQ: begin
                done_out <= 1'b1;
                unique_r <= op_a0_in;
              end
              `OP_URTI: begin
                if (!user_mode) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_MCHK;
                end else if (op_sp_in[5:0] != 6'h00) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_ILLOP;
                end else begin
                  state_r      <= S_MEM;
                  busy_out     <= 1'b1;
                  base_r       <= op_sp_in;
                  last_r       <= `URTI_STEPS;
                  mem_req_out  <= 1'b1;
                  mem_we_out   <= 1'b0;
                  mem_addr_out <= op_sp_in;
                end
              end
              `OP_IMB: begin
                done_out <= 1'b1;
              end
              `OP_CFLUSH: begin
                if (user_mode) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_RSVD;
                end else begin
                  done_out      <= 1'b1;
                  flush_out     <= 1'b1;
                  flush_pfn_out <= op_a0_in;
                end
              end
              default: begin
                exc_out      <= 1'b1;
                exc_code_out <= `EXC_RSVD;
              end
            endcase
          end
        end
        S_MEM: begin
          if (mem_err_in) begin
            // abort: no register or status is updated yet; frame words already acked stay in memory
            state_r      <= S_IDLE;
            busy_out     <= 1'b0;
            mem_req_out  <= 1'b0;
            mem_we_out   <= 1'b0;
            exc_out      <= 1'b1;
            exc_code_out <= (op_r == `OP_URTI) ? `EXC_MEMF : `EXC_KSNV;
          end else if (mem_ack_in) begin
            if (step_r != last_r) begin
              step_r <= step_r + 3'h1;
              if (op_r == `OP_CLRFEN) begin
                mem_we_out    <= 1'b1;
                mem_wdata_out <= {mem_rdata_in[DW-1:1], 1'b0};
              end else begin
                mem_addr_out  <= mem_addr_out + `QW_STEP;
                mem_wdata_out <= frame_word(step_r + 3'h1);
              end
            end else begin
              state_r     <= S_IDLE;
              busy_out    <= 1'b0;
              mem_req_out <= 1'b0;
              mem_we_out  <= 1'b0;
              if (op_r == `OP_CLRFEN) begin
                done_out             <= 1'b1;
                float_enable_bit_out <= 1'b0;
              end else if (op_r == `OP_URTI) begin
                if (!urti_ps[`ST_MODE] || urti_ps[2:0] != 3'h0) begin
                  exc_out      <= 1'b1;
                  exc_code_out <= `EXC_ILLOP;
                end else begin
                  done_out    <= 1'b1;
                  intr_flag_r <= 1'b0;
                  lock_flag_r <= 1'b0;
                  res_at_out  <= ld_r[0];
                  res_sp_out  <= ld_r[1];
                  res_pc_out  <= ld_r[3];
                  res_gp_out  <= ld_r[4];
                  res_a0_out  <= ld_r[5];
                  res_a1_out  <= ld_r[6];
                  res_a2_out  <= mem_rdata_in;
                  res_we_out  <= 8'hDF;
                end
              end else begin
                done_out   <= 1'b1;
                if (user_r) begin
                  user_stack_save_r <= sp_l_r;
                  status_out        <= `ST_RST;
                end
                res_sp_out <= base_r;
                res_gp_out <= kernel_global_ptr_r;
                if (op_r == `OP_CALLSYS) begin
                  res_pc_out <= syscall_vector_r;
                  res_we_out <= 8'h83;
                end else begin
                  res_pc_out <= instr_fault_vector_r;
                  res_a0_out <= {{(DW-2){1'b0}}, op_r[1:0]};
                  res_we_out <= 8'h87;
                end
              end
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      // hardware sets win over any clear in the same cycle
      if (lock_set_in) begin
        lock_flag_r <= 1'b1;
      end
      if (intr_set_in) begin
        intr_flag_r <= 1'b1;
      end
    end
  end

endmodule

//--- tb/stack_mem_model.sv
`timescale 1ns/1ps
module stack_mem_model (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        req_in,
  input  wire        we_in,
  input  wire [63:0] addr_in,
  input  wire [63:0] wdata_in,
  input  wire        slow_in,
  input  wire        err_in,
  output reg  [63:0] rdata_out = 64'h0,
  output reg         ack_out = 1'b0,
  output reg         err_out = 1'b0
);
  logic [63:0] mem [logic [63:0]];
  int          wait_cnt;

  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    err_out <= 1'b0;
    // read data is only meaningful in the ack cycle, so keep it moving otherwise
    rdata_out <= ~rdata_out;
    if (!rst_n_in) begin
      wait_cnt <= 0;
    end else if (req_in && !ack_out && !err_out) begin
      if (wait_cnt < (slow_in ? 3 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        if (err_in) begin
          err_out <= 1'b1;
        end else begin
          ack_out <= 1'b1;
          if (we_in) begin
            mem[addr_in] = wdata_in;
          end else begin
            rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 64'h0;
          end
        end
      end
    end
  end
endmodule

//--- tb/trap_call_return_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "trap_seq_regs.vh"
module trap_call_return_sequencer_tb_top;
  localparam logic [63:0] KGR_V = 64'h0000_0000_0000_1100;
  localparam logic [63:0] KSS_V = 64'h0000_0000_0000_2000;
  localparam logic [63:0] IFV_V = 64'h0000_0000_0000_3000;
  localparam logic [63:0] SYV_V = 64'h0000_0000_0000_4000;
  localparam logic [63:0] CBB_V = 64'h0000_0000_0000_5000;
  localparam logic [63:0] FRM_V = 64'h0000_0000_0000_8000;
  localparam logic [63:0] UQ_V  = 64'h0123_4567_89ab_cdef;
  reg         mclk_in, rst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  reg         op_valid_in = 1'b0, lock_set_in = 1'b0, intr_set_in = 1'b0, slow = 1'b0, err_arm = 1'b0;
  reg  [5:0]  wb_adr_in = 6'h0;
  reg  [7:0]  wb_sel_in = 8'hff;
  reg  [3:0]  op_code_in = 4'h0;
  reg  [63:0] wb_dat_in = 64'h0, op_pc_next_in = 64'h0, op_sp_in = 64'h0, op_a0_in = 64'h0;
  reg  [63:0] op_gp_in = 64'h0000_0000_0000_0600, op_a1_in = ~UQ_V, op_a2_in = UQ_V ^ KGR_V;
  wire [63:0] wb_dat_out, res_sp_out, res_gp_out, res_a0_out, res_a1_out, res_a2_out, res_v0_out;
  wire [63:0] res_at_out, res_pc_out, flush_pfn_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
  wire        wb_ack_out, busy_out, done_out, exc_out, flush_out, float_enable_bit_out;
  wire        mem_req_out, mem_we_out, mem_ack_in, mem_err_in;
  wire [7:0]  res_we_out;
  wire [2:0]  exc_code_out;
  wire [3:0]  status_out;
  int         miscompares = 0, checks_done = 0;
  reg  [63:0] rd;

  trap_call_return_sequencer i_trap_call_return_sequencer (
    .mclk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .wb_dat_out, .wb_ack_out, .op_valid_in, .op_code_in, .op_pc_next_in, .op_sp_in, .op_gp_in,
    .op_a0_in, .op_a1_in, .op_a2_in, .lock_set_in, .intr_set_in, .busy_out, .done_out,
    .res_we_out, .res_sp_out, .res_gp_out, .res_a0_out, .res_a1_out, .res_a2_out, .res_v0_out,
    .res_at_out, .res_pc_out, .exc_out, .exc_code_out, .flush_out, .flush_pfn_out, .status_out,
    .float_enable_bit_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
    .mem_rdata_in, .mem_ack_in, .mem_err_in);
  stack_mem_model i_mem (
    .clk_in(mclk_in), .rst_n_in, .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .slow_in(slow), .err_in(err_arm),
    .rdata_out(mem_rdata_in), .ack_out(mem_ack_in), .err_out(mem_err_in));

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function logic [63:0] qw(input logic [63:0] base, input int k);
    return i_mem.mem[base + k * `QW_STEP];
  endfunction
  task wb(input logic we, input logic [5:0] a, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      finish_test;
    end
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  // the pc handed over is ~sp so every frame slot is distinct
  task op(input logic [3:0] c, input logic [63:0] sp, input logic [63:0] a0);
    int n;
    n = 0;
    @(posedge mclk_in);
    op_valid_in   <= 1'b1;
    op_code_in    <= c;
    op_sp_in      <= sp;
    op_a0_in      <= a0;
    op_pc_next_in <= ~sp;
    do begin
      @(posedge mclk_in);
      op_valid_in <= 1'b0;
      #1;
      n++;
    end while (done_out !== 1'b1 && exc_out !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      finish_test;
    end
  endtask
  task exc(input logic [2:0] c);
    chk(exc_out, 1'b1);
    chk(exc_code_out, c);
  endtask
  task user_mode;
    wb(1'b1, `REG_CTRL, {56'h0, 8'h18});
  endtask

  task t_regs;
    wb(1'b0, `REG_CTRL, 64'h0);
    chk(rd, 64'h0);
    wb(1'b1, `REG_KPTR, KGR_V);
    wb(1'b1, `REG_KSS, KSS_V);
    wb(1'b1, `REG_IFVEC, IFV_V);
    wb(1'b1, `REG_SYSVEC, SYV_V);
    wb(1'b1, `REG_CBB, CBB_V);
    wb(1'b0, `REG_KSS, 64'h0);
    chk(rd, KSS_V);
    $display("registers done");
  endtask
  task t_traps;
    logic [63:0] fb;
    fb = KSS_V - `FRAME_BYTES;
    for (int c = 0; c < 3; c++) begin
      slow = (c == 1);
      user_mode;
      op(c[3:0], FRM_V, UQ_V);
      chk(res_we_out, 8'h87);
      chk(res_sp_out, fb);
      chk(res_a0_out, c);
      chk(res_gp_out, KGR_V);
      chk(res_pc_out, IFV_V);
      chk(qw(fb, 0), 64'h8);
      chk(qw(fb, 1), ~FRM_V);
      chk(qw(fb, 2), op_gp_in);
      chk(qw(fb, 3), UQ_V);
      chk(qw(fb, 5), op_a2_in);
      wb(1'b0, `REG_CTRL, 64'h0);
      chk(rd[3:0], 4'h0);
      wb(1'b0, `REG_USS, 64'h0);
      chk(rd, FRM_V);
    end
    slow = 1'b0;
    op(`OP_GENTRAP, KSS_V, UQ_V);
    chk(res_sp_out, fb);
    chk(qw(fb, 0), 64'h0);
    $display("traps done");
  endtask
  task t_kernel;
    op(`OP_CALLSYS, FRM_V, UQ_V);
    exc(`EXC_MCHK);
    op(`OP_URTI, FRM_V, UQ_V);
    exc(`EXC_MCHK);
    op(`OP_CFLUSH, FRM_V, UQ_V);
    chk(flush_out, 1'b1);
    chk(flush_pfn_out, UQ_V);
    op(`OP_IMB, FRM_V, UQ_V);
    chk(done_out, 1'b1);
    $display("kernel refusals done");
  endtask
  task t_sys;
    logic [63:0] fb;
    fb = KSS_V - `FRAME_BYTES;
    user_mode;
    op(`OP_WRUNIQ, FRM_V, UQ_V);
    chk(exc_out, 1'b0);
    op(`OP_RDUNIQ, FRM_V, 64'h0);
    chk(res_v0_out, UQ_V);
    op(`OP_CFLUSH, FRM_V, UQ_V);
    exc(`EXC_RSVD);
    op(`OP_CALLSYS, FRM_V, UQ_V);
    chk(qw(fb, 0), `ST_SYSCALL);
    chk(qw(fb, 1), ~FRM_V);
    chk(qw(fb, 2), op_gp_in);
    chk(res_sp_out, fb);
    chk(res_gp_out, KGR_V);
    chk(res_pc_out, SYV_V);
    wb(1'b0, `REG_CTRL, 64'h0);
    chk(rd[3:0], 4'h0);
    user_mode;
    i_mem.mem[CBB_V + `FLT_OFF] = 64'h0000_0000_0000_00ff;
    op(`OP_CLRFEN, FRM_V, 64'h0);
    chk(qw(CBB_V, 5), 64'h0000_0000_0000_00fe);
    chk(float_enable_bit_out, 1'b0);
    $display("user calls done");
  endtask
  task t_urti;
    for (int i = 0; i < 8; i++) i_mem.mem[FRM_V + i * `QW_STEP] = SYV_V + i;
    i_mem.mem[FRM_V + 2 * `QW_STEP] = 64'h8;
    user_mode;
    @(posedge mclk_in);
    lock_set_in <= 1'b1;
    intr_set_in <= 1'b1;
    @(posedge mclk_in);
    lock_set_in <= 1'b0;
    intr_set_in <= 1'b0;
    op(`OP_URTI, FRM_V + `QW_STEP, 64'h0);
    exc(`EXC_ILLOP);
    wb(1'b0, `REG_CTRL, 64'h0);
    chk(rd[6:5], 2'b11);
    slow = 1'b1;
    op(`OP_URTI, FRM_V, 64'h0);
    chk(res_we_out, 8'hdf);
    chk(res_at_out, SYV_V);
    chk(res_sp_out, SYV_V + 1);
    chk(res_pc_out, SYV_V + 3);
    chk(res_gp_out, SYV_V + 4);
    chk(res_a0_out, SYV_V + 5);
    chk(res_a1_out, SYV_V + 6);
    chk(res_a2_out, SYV_V + 7);
    wb(1'b0, `REG_CTRL, 64'h0);
    chk(rd[6:5], 2'b00);
    slow = 1'b0;
    i_mem.mem[FRM_V + 2 * `QW_STEP] = 64'h9;
    op(`OP_URTI, FRM_V, 64'h0);
    exc(`EXC_ILLOP);
    i_mem.mem[FRM_V + 2 * `QW_STEP] = 64'h0;
    op(`OP_URTI, FRM_V, 64'h0);
    exc(`EXC_ILLOP);
    $display("user trap return done");
  endtask
  task t_faults;
    user_mode;
    err_arm = 1'b1;
    op(`OP_BPT, FRM_V, UQ_V);
    exc(`EXC_KSNV);
    err_arm = 1'b0;
    wb(1'b0, `REG_CTRL, 64'h0);
    chk(rd[3:0], 4'h8);
    wb(1'b1, `REG_CTRL, 64'h0);
    op(`OP_BUGCHK, FRM_V + 64'h4, UQ_V);
    exc(`EXC_KSNV);
    $display("stack faults done");
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_traps;
    t_kernel;
    t_sys;
    t_urti;
    t_faults;
    finish_test;
  end
endmodule

//--- tb/trap_seq_chk.sv
`timescale 1ns/1ps
`include "trap_seq_regs.vh"
module trap_seq_chk #(
  parameter DW = 64
) (
  input wire          mclk_in,
  input wire          rst_n_in,
  input wire          op_valid_in,
  input wire [3:0]    op_code_in,
  input wire [DW-1:0] op_sp_in,
  input wire [DW-1:0] op_a0_in,
  input wire          busy_out,
  input wire          done_out,
  input wire [7:0]    res_we_out,
  input wire          exc_out,
  input wire [2:0]    exc_code_out,
  input wire          flush_out,
  input wire [DW-1:0] flush_pfn_out,
  input wire [3:0]    status_out,
  input wire          mem_req_out,
  input wire [DW-1:0] mem_addr_out,
  input wire [DW-1:0] mem_wdata_out,
  input wire          mem_ack_in,
  input wire          mem_err_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence take(logic [3:0] c);
    op_valid_in && !busy_out && op_code_in == c;
  endsequence
  sequence raised(logic [2:0] c);
    exc_out && exc_code_out == c;
  endsequence

  AST_SYS_KERNEL: assert property (take(`OP_CALLSYS) ##0 !status_out[3] |=> raised(`EXC_MCHK))
    else $error("kernel system call not refused");
  AST_URTI_KERNEL: assert property (take(`OP_URTI) ##0 !status_out[3] |=> raised(`EXC_MCHK))
    else $error("kernel user-trap return not refused");
  AST_URTI_ALIGN: assert property (take(`OP_URTI) ##0 status_out[3] && op_sp_in[5:0] != 6'h0
    |=> raised(`EXC_ILLOP))
    else $error("unaligned user-trap return frame accepted");
  AST_FLUSH_USER: assert property (take(`OP_CFLUSH) ##0 status_out[3] |=> raised(`EXC_RSVD))
    else $error("user cache flush not refused");
  AST_FLUSH_KERNEL: assert property (take(`OP_CFLUSH) ##0 !status_out[3]
    |=> flush_out && flush_pfn_out == $past(op_a0_in))
    else $error("kernel cache flush wrong or missing");
  AST_RDUNIQ: assert property (take(`OP_RDUNIQ) |=> done_out && res_we_out[`RES_V0] && !exc_out)
    else $error("read unique did not complete");
  AST_WRUNIQ: assert property (take(`OP_WRUNIQ) |=> done_out && !exc_out)
    else $error("write unique did not complete");
  AST_ABORT_CLEAN: assert property (exc_out |-> res_we_out == 8'h00 && !done_out)
    else $error("exception with register update");
  AST_MEM_HOLD: assert property (mem_req_out && !mem_ack_in && !mem_err_in
    |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_wdata_out))
    else $error("stack request changed before answer");
  AST_BUSY_BOUND: assert property ($rose(busy_out) |-> ##[1:300] !busy_out)
    else $error("flow never finished");
endmodule

bind trap_call_return_sequencer trap_seq_chk #(.DW(DW)) i_trap_seq_chk (
  .mclk_in, .rst_n_in, .op_valid_in, .op_code_in, .op_sp_in, .op_a0_in, .busy_out,
  .done_out, .res_we_out, .exc_out, .exc_code_out, .flush_out, .flush_pfn_out,
  .status_out, .mem_req_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_err_in
);
